// >>> rtl/reload_pwm_timer.sv
`timescale 1ns/100ps
module reload_pwm_timer (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Control fields written by software.
  input wire reload_pwm_timer_pkg::timer_ctrl_t timer_ctrl,
  input wire reload_pwm_timer_pkg::pwm_ctrl_t pwm_ctrl,
  input wire reload_pwm_timer_pkg::cap_ctrl_t cap_ctrl,
  input wire logic [7:0] reload_value_reg,
  input wire logic [31:0] duty_cycle_reg,
  // Software access strobes, one cycle each.
  input wire logic force_reload,
  input wire logic counter_write,
  input wire logic [7:0] counter_write_data,
  input wire logic status_read,
  input wire logic [1:0] capture_read,
  // System mode.
  input wire logic halt_mode,
  // Pins.
  input wire logic external_count_clock,
  input wire logic [1:0] capture_input_pin,
  output logic [3:0] pwm_output,
  output logic [3:0] pwm_output_en_n,
  // Status back to software.
  output logic [7:0] counter_access_reg,
  output logic overflow_flag,
  output logic [1:0] capture_flag,
  output logic [15:0] capture_value_reg,
  output logic force_reload_readback,
  // Interrupt requests and wake-up.
  output logic overflow_irq,
  output logic [1:0] capture_irq,
  output logic wakeup_req
);

  // Counter, prescaler, flag and raw PWM state.
  logic [7:0] counter_r, counter_nxt;
  logic [6:0] prescaler_r, prescaler_nxt;
  logic ovf_r, ovf_nxt;
  logic [3:0] raw_r, raw_nxt;
  logic [31:0] shadow_r, shadow_nxt;
  // External clock synchroniser and its edge history.
  logic ext_s1_r, ext_s2_r, ext_h_r;
  logic ext_rise;
  logic tick;
  logic tap;
  logic overflow;
  logic [15:0] prescaler_wide;

  // Selects prescaler bit n; tap 0 is bit 0, used by selection 1 for one tick per two input ticks.
  function automatic logic tap_of(input logic [15:0] pre,
                                  input logic [2:0] sel);
    tap_of = pre[sel];
  endfunction : tap_of

  // External clock crosses into clk through two flip-flops first.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_h_r <= 1'b0;
    end else begin
      ext_s1_r <= external_count_clock;
      ext_s2_r <= ext_s1_r;
      ext_h_r <= ext_s2_r;
    end
  end

  assign ext_rise = ext_s2_r & ~ext_h_r;

  // The prescaler input pulse: every CPU clock or each external rise.
  // The external path is limited to well under half the CPU rate
  // because it is sampled, a cost of keeping one clock domain.
  logic input_tick;
  assign input_tick = timer_ctrl.clock_source_select ? ext_rise : 1'b1;

  // The tap of the running prescaler; selection 0 bypasses it.
  // Bit n of the count toggles every 2^n inputs, so a falling of bit
  // n-1 marks one output tick per 2^n input ticks.
  assign prescaler_wide = {9'h000, prescaler_r};
  always_comb begin
    if (timer_ctrl.prescale_select == 3'h0) begin
      tap = 1'b0;
      tick = timer_ctrl.count_enable & input_tick;
    end else begin
      tap = tap_of(prescaler_wide, 3'(timer_ctrl.prescale_select - 3'h1));
      tick = timer_ctrl.count_enable & input_tick & tap &
             (prescaler_r[6:0] ==
              (prescaler_r[6:0] | 7'((16'hFFFF >>
               (5'h10 - 5'(timer_ctrl.prescale_select))))));
    end
  end

  assign overflow = tick && (counter_r == reload_pwm_timer_pkg::CNT_MAX);

  // Next values of counter, prescaler, flag and PWM levels.
  always_comb begin
    counter_nxt = counter_r;
    prescaler_nxt = prescaler_r;
    ovf_nxt = ovf_r;
    raw_nxt = raw_r;
    shadow_nxt = shadow_r;
    // Freeze the count while count enable is clear; a counter write still loads it.
    if (timer_ctrl.count_enable && input_tick) begin
      prescaler_nxt = prescaler_r + 7'h01;
    end
    if (tick) begin
      if (overflow) begin
        counter_nxt = reload_value_reg;
        shadow_nxt = duty_cycle_reg;
      end else begin
        counter_nxt = counter_r + 8'h01;
      end
    end
    // PWM edges: overflow sets the active phase, match ends it.
    for (int i = 0; i < reload_pwm_timer_pkg::NUM_PWM; i++) begin
      if (overflow) begin
        raw_nxt[i] = 1'b1;
      end else if (tick && (counter_nxt == shadow_r[8*i +: 8])) begin
        raw_nxt[i] = 1'b0;
      end
    end
    // Software initialisation clears the prescaler as well.
    if (counter_write) begin
      counter_nxt = counter_write_data;
      prescaler_nxt = reload_pwm_timer_pkg::PRE_RST;
    end else if (force_reload && timer_ctrl.count_enable) begin
      counter_nxt = reload_value_reg;
      prescaler_nxt = reload_pwm_timer_pkg::PRE_RST;
    end
    if (status_read) begin
      ovf_nxt = 1'b0;
    end
    if (overflow) begin
      ovf_nxt = 1'b1;
    end
  end

  // State registers; reset clears counter, prescaler, flag, PWM levels and shadow.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      counter_r <= reload_pwm_timer_pkg::CNT_RST;
      prescaler_r <= reload_pwm_timer_pkg::PRE_RST;
      ovf_r <= 1'b0;
      raw_r <= 4'h0;
      shadow_r <= 32'h0000_0000;
    end else begin
      counter_r <= counter_nxt;
      prescaler_r <= prescaler_nxt;
      ovf_r <= ovf_nxt;
      raw_r <= raw_nxt;
      shadow_r <= shadow_nxt;
    end
  end

  // Polarity applied combinationally so a change shows at once.
  // In halt the outputs are released rather than driven.
  always_comb begin
    for (int i = 0; i < reload_pwm_timer_pkg::NUM_PWM; i++) begin
      pwm_output[i] = raw_r[i] ^ pwm_ctrl.channel_polarity[i];
      pwm_output_en_n[i] = ~(pwm_ctrl.channel_output_enable[i] &
                             ~halt_mode);
    end
  end

  // Two capture channels.
  logic [1:0] cap_flag;
  for (genvar c = 0; c < reload_pwm_timer_pkg::NUM_CAP; c++) begin : g_cap
    capture_channel u_cap (
      .clk(clk),
      .reset_n(reset_n),
      .capture_input_pin(capture_input_pin[c]),
      .capture_edge_select(cap_ctrl.capture_edge_select[c]),
      .counter_value(counter_r),
      .read_strobe(capture_read[c]),
      .capture_value_reg(capture_value_reg[8*c +: 8]),
      .capture_flag(cap_flag[c])
    );
  end

  // Status and interrupt outputs.
  assign capture_flag = cap_flag;
  assign counter_access_reg = counter_r;
  assign overflow_flag = ovf_r;
  assign force_reload_readback = 1'b0;
  assign overflow_irq = ovf_r & timer_ctrl.overflow_irq_enable;
  assign capture_irq = cap_flag & cap_ctrl.capture_irq_enable;
  assign wakeup_req = overflow_irq | (|capture_irq);

  // Overflow sets the flag on the next edge.
  AST_OVF_SET: assert property (@(posedge clk) disable iff (!reset_n)
    overflow |=> ovf_r) else $error("overflow flag not set");
  // A read alone clears it.
  AST_OVF_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    status_read && !overflow |=> !ovf_r) else $error("flag not cleared");
  // Overflow reloads the counter.
  AST_RELOAD: assert property (@(posedge clk) disable iff (!reset_n)
    overflow && !counter_write && !force_reload |=>
    counter_r == $past(reload_value_reg))
    else $error("counter not reloaded");
  // Frozen when disabled.
  AST_FREEZE: assert property (@(posedge clk) disable iff (!reset_n)
    !timer_ctrl.count_enable && !counter_write |=> $stable(counter_r) &&
    $stable(prescaler_r)) else $error("counter moved while disabled");
  // Counter write clears prescaler and loads counter.
  AST_CWRITE: assert property (@(posedge clk) disable iff (!reset_n)
    counter_write |=> prescaler_r == 7'h00 &&
    counter_r == $past(counter_write_data)) else $error("bad write");
  // Shadow loads only at overflow.
  AST_SHADOW: assert property (@(posedge clk) disable iff (!reset_n)
    !overflow |=> $stable(shadow_r)) else $error("shadow changed");
  // Overflow starts the active phase.
  AST_PWM_SET: assert property (@(posedge clk) disable iff (!reset_n)
    overflow |=> raw_r == 4'hF) else $error("pwm not set");
  // Capture interrupt 0 follows flag 0 and its enable.
  AST_CAP_IRQ: assert property (@(posedge clk) disable iff (!reset_n)
    cap_flag[0] && cap_ctrl.capture_irq_enable[0] |-> capture_irq[0])
    else $error("capture irq missing");
  // Force-reload readback is zero.
  AST_FORCE_RELOAD_RD: assert property (@(posedge clk) disable iff (!reset_n)
    force_reload |-> !force_reload_readback)
    else $error("force reload read nonzero");

endmodule : reload_pwm_timer

// >>> rtl/reload_pwm_timer_pkg.sv
package reload_pwm_timer_pkg;

  // Counter width and reset values.
  localparam int CNT_W = 8;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;

  // Prescaler width and reset value.
  localparam int PRE_W = 7;
  localparam logic [6:0] PRE_RST = 7'h00;

  // Number of PWM channels and capture channels.
  localparam int NUM_PWM = 4;
  localparam int NUM_CAP = 2;

  // Timer control fields as seen by software.
  typedef struct packed {
    logic clock_source_select;
    logic [2:0] prescale_select;
    logic count_enable;
    logic overflow_irq_enable;
  } timer_ctrl_t;

  // PWM control fields.
  typedef struct packed {
    logic [3:0] channel_output_enable;
    logic [3:0] channel_polarity;
  } pwm_ctrl_t;

  // Capture control fields.
  typedef struct packed {
    logic [1:0] capture_edge_select;
    logic [1:0] capture_irq_enable;
  } cap_ctrl_t;

endpackage : reload_pwm_timer_pkg

// >>> rtl/capture_channel.sv
`timescale 1ns/100ps
// One input capture channel: synchronise, detect the chosen edge, latch.
module capture_channel (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Pin and control.
  input wire logic capture_input_pin,
  input wire logic capture_edge_select,
  input wire logic [7:0] counter_value,
  input wire logic read_strobe,
  // Results.
  output logic [7:0] capture_value_reg,
  output logic capture_flag
);

  // Two-stage synchroniser plus one history stage for edge detection.
  logic sync1_r, sync2_r, hist_r;
  logic sync1_nxt, sync2_nxt, hist_nxt;
  logic [7:0] value_r, value_nxt;
  logic flag_r, flag_nxt;
  logic edge_hit;

  // Next-state logic for the whole channel.
  always_comb begin
    sync1_nxt = capture_input_pin;
    sync2_nxt = sync1_r;
    hist_nxt = sync2_r;
    // A rising edge when the select bit is set, falling edge otherwise.
    edge_hit = capture_edge_select ? (sync2_r & ~hist_r)
                                   : (~sync2_r & hist_r);
    value_nxt = value_r;
    flag_nxt = flag_r;
    if (read_strobe) begin
      flag_nxt = 1'b0;
    end
    // The value is only taken while the flag is clear, so an unread
    // capture is never overwritten. A clearing read beats a new edge, which is lost.
    if (edge_hit && !flag_r) begin
      value_nxt = counter_value;
      flag_nxt = 1'b1;
    end
  end

  // Registers of the channel.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      hist_r <= 1'b0;
      value_r <= reload_pwm_timer_pkg::CNT_RST;
      flag_r <= 1'b0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      hist_r <= hist_nxt;
      value_r <= value_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign capture_value_reg = value_r;
  assign capture_flag = flag_r;

endmodule : capture_channel

// >>> verification/pin_model.sv
`timescale 1ns/100ps
// Far-side pins: external count clock and the two capture inputs.
module pin_model (
  // Clock used to pace pin changes.
  input wire logic clk,
  // Pins driven towards the timer.
  output logic ext_clk,
  output logic [1:0] cap_pin
);
  // The external clock stands low between bursts so no stray count appears.
  initial begin
    ext_clk = 1'b0;
    cap_pin = 2'b00;
  end

  // Pulses repeat every five cycles, high for two, slower than clk/4 as the synchroniser needs.
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge clk) ext_clk <= 1'b1;
      repeat (2) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask : ext_pulses

  // Sets one capture pin to a level at the next edge.
  task automatic cap_set(input int c, input logic v);
    @(posedge clk) cap_pin[c] <= v;
  endtask : cap_set
endmodule : pin_model

// >>> verification/pwm_autoreload_timer_test.sv
`timescale 1ns/100ps
// Directed checks of counter, prescaler, PWM, capture and event counting.
module pwm_autoreload_timer_test;
  logic clk, reset_n, force_reload, counter_write, status_read, halt_mode;
  reload_pwm_timer_pkg::timer_ctrl_t timer_ctrl;
  reload_pwm_timer_pkg::pwm_ctrl_t pwm_ctrl;
  reload_pwm_timer_pkg::cap_ctrl_t cap_ctrl;
  logic [7:0] reload_value_reg, counter_write_data, counter_access_reg;
  logic [31:0] duty_cycle_reg;
  logic [1:0] capture_read, capture_input_pin, capture_flag, capture_irq;
  logic external_count_clock, overflow_flag, force_reload_readback;
  logic [3:0] pwm_output, pwm_output_en_n;
  logic [15:0] capture_value_reg;
  logic overflow_irq, wakeup_req;
  int err_count = 0;
  int comparisons = 0;

  reload_pwm_timer i_dut (.clk, .reset_n, .timer_ctrl, .pwm_ctrl,
    .cap_ctrl, .reload_value_reg, .duty_cycle_reg, .force_reload,
    .counter_write, .counter_write_data, .status_read, .capture_read,
    .halt_mode, .external_count_clock, .capture_input_pin, .pwm_output,
    .pwm_output_en_n, .counter_access_reg, .overflow_flag, .capture_flag,
    .capture_value_reg, .force_reload_readback, .overflow_irq,
    .capture_irq, .wakeup_req);

  pin_model i_pins (.clk, .ext_clk(external_count_clock),
    .cap_pin(capture_input_pin));

  // Free-running 50 ns clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task report_and_stop();
    $display("Errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Compares one observed value with its expectation.
  task chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Waits a few edges and lets their updates settle.
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Waits, under a bound, until the counter shows a value.
  task automatic wait_cnt(input logic [7:0] v);
    int n;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (counter_access_reg !== v && n < 2000);
    if (n >= 2000) begin
      err_count++;
      report_and_stop();
    end
  endtask : wait_cnt

  // Waits, under a bound, for a capture flag.
  task automatic wait_cap(input int c);
    int n;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (capture_flag[c] !== 1'b1 && n < 12);
    chk(16'(capture_flag[c]), 16'h0001);
  endtask : wait_cap

  // One-cycle counter load through the access strobe.
  task cnt_write(input logic [7:0] v);
    @(posedge clk) counter_write <= 1'b1;
    counter_write_data <= v;
    @(posedge clk) counter_write <= 1'b0;
    #1;
  endtask : cnt_write

  initial begin
    reset_n = 1'b0;
    timer_ctrl = '0;
    pwm_ctrl = '0;
    cap_ctrl = '0;
    reload_value_reg = 8'h00;
    duty_cycle_reg = 32'h00000000;
    {force_reload, counter_write, status_read, halt_mode} = 4'h0;
    counter_write_data = 8'h00;
    capture_read = 2'b00;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    cyc(1);
    chk(16'(counter_access_reg), 16'h0000);
    chk(16'(overflow_flag), 16'h0000);
    chk(16'(force_reload_readback), 16'h0000);
    chk(16'(pwm_output_en_n), 16'h000F);
    // Walk: reload FE, force reload, then FF and back to FE.
    @(posedge clk) timer_ctrl <= '{1'b0, 3'h0, 1'b1, 1'b1};
    reload_value_reg <= 8'hFE;
    @(posedge clk) force_reload <= 1'b1;
    @(posedge clk) force_reload <= 1'b0;
    #1 chk(16'(counter_access_reg), 16'h00FE);
    cyc(1);
    chk(16'(counter_access_reg), 16'h00FF);
    cyc(1);
    chk(16'(counter_access_reg), 16'h00FE);
    chk(16'({overflow_flag, overflow_irq}), 16'h0003);
    cnt_write(8'h5A);
    chk(16'(counter_access_reg), 16'h005A);
    // Freezing must hold the count still.
    @(posedge clk) timer_ctrl.count_enable <= 1'b0;
    @(posedge clk) status_read <= 1'b1;
    @(posedge clk) status_read <= 1'b0;
    #1 chk(16'(overflow_flag), 16'h0000);
    chk(16'(counter_access_reg), 16'h005B);
    cyc(5);
    chk(16'(counter_access_reg), 16'h005B);
    // Every tap: four counter ticks take 4 * 2^s input clocks.
    @(posedge clk) timer_ctrl.count_enable <= 1'b1;
    reload_value_reg <= 8'h00;
    for (int s = 0; s < 8; s++) begin
      @(posedge clk) timer_ctrl.prescale_select <= 3'(s);
      cnt_write(8'h00);
      cyc(4 << s);
      chk(16'(counter_access_reg), 16'h0004);
    end
    // PWM with duties above the reload value, polarity 0.
    @(posedge clk) timer_ctrl.prescale_select <= 3'h0;
    reload_value_reg <= 8'hF0;
    duty_cycle_reg <= 32'hFAF8F6F4;
    pwm_ctrl <= 8'hF0;
    wait_cnt(8'hFF);
    wait_cnt(8'hF2);
    chk(16'(pwm_output), 16'h000F);
    chk(16'(pwm_output_en_n), 16'h0000);
    @(posedge clk) duty_cycle_reg[7:0] <= 8'hF1;
    wait_cnt(8'hFC);
    chk(16'(pwm_output), 16'h0000);
    @(posedge clk) pwm_ctrl.channel_polarity <= 4'hF;
    #1 chk(16'(pwm_output), 16'h000F);
    @(posedge clk) pwm_ctrl.channel_polarity <= 4'h0;
    wait_cnt(8'hF5);
    chk(16'(pwm_output), 16'h000E);
    @(posedge clk) halt_mode <= 1'b1;
    #1 chk(16'(pwm_output_en_n), 16'h000F);
    @(posedge clk) halt_mode <= 1'b0;
    timer_ctrl.count_enable <= 1'b0;
    // Capture: ch0 rising, ch1 falling, both interrupts on.
    cap_ctrl <= 4'b0111;
    cnt_write(8'h5A);
    i_pins.cap_set(0, 1'b1);
    wait_cap(0);
    chk(16'({capture_irq[0], capture_value_reg[7:0]}), 16'h015A);
    cnt_write(8'h33);
    i_pins.cap_set(0, 1'b0);
    i_pins.cap_set(0, 1'b1);
    cyc(8);
    chk(16'(capture_value_reg[7:0]), 16'h005A);
    @(posedge clk) capture_read <= 2'b01;
    @(posedge clk) capture_read <= 2'b00;
    #1 chk(16'(capture_flag), 16'h0000);
    i_pins.cap_set(1, 1'b1);
    cyc(8);
    chk(16'(capture_flag), 16'h0000);
    i_pins.cap_set(1, 1'b0);
    wait_cap(1);
    chk(16'(capture_value_reg[15:8]), 16'h0033);
    // Event counting: three external edges from FD reach overflow.
    @(posedge clk) timer_ctrl <= '{1'b1, 3'h0, 1'b1, 1'b1};
    reload_value_reg <= 8'hFD;
    @(posedge clk) force_reload <= 1'b1;
    @(posedge clk) force_reload <= 1'b0;
    status_read <= 1'b1;
    @(posedge clk) status_read <= 1'b0;
    i_pins.ext_pulses(2);
    cyc(6);
    chk(16'({overflow_flag, counter_access_reg}), 16'h00FF);
    i_pins.ext_pulses(1);
    cyc(6);
    chk(16'({overflow_flag, counter_access_reg}), 16'h01FD);
    chk(16'({overflow_irq, wakeup_req}), 16'h0003);
    report_and_stop();
  end
endmodule : pwm_autoreload_timer_test
